// [hw/crxs_sequencer.sv]
// Coprocessor register transfer sequencer: drives the core's bus strobes for
// transfers to and from a coprocessor, the undefined trap and failed-condition
// cycles, and reports instruction cycle costs over an Avalon-MM slave.
// Assumes a single 20 MHz clock and coprocessor lines synchronous to it.
//
// How it works
// - Coprocessor-to-core move carries one word, written to destination in cycle three.
// - The write-back cycle doubles as the next prefetch, one sequential memory cycle.
// - Ready load: fetch pc+8, then pc+12 with coprocessor data, then sequential memory cycle at pc+12.
// - Absent low, busy high: idle at pc+8, last wait marked sequential.
// - Core-to-coprocessor move: no internal cycle; writes source at pc+12 nonsequentially.
// - No coprocessor handshake while in compressed instruction state.
// - Both handshake lines high on an offered instruction takes the undefined trap.
// - Trap: two cycles at pc+2L, then vector and vector+4 in trap mode.
// - A failed-condition instruction does nothing and costs one sequential cycle.
// - That cycle fetches sequentially at pc+2L, then the address moves to pc+3L.
// - Multiply termination count from the sign spread of the multiplier.
// - Data processing and status moves cycle counts.
// - Load, store, block and swap cycle counts.
// - Multiply family cycle counts.
// - Coprocessor instruction cycle counts, b being busy-wait cycles.
// - Branches and software interrupts take two sequential plus one nonsequential.
`timescale 1ns/10ps
`include "crxs_defines.svh"

module crxs_sequencer
    import crxs_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Avalon-MM register slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Core memory interface
    output logic [31:0] mem_addr,
    output logic [1:0] access_size,
    output logic write_not_read,
    output logic mem_request_n,
    output logic sequential_access,
    output logic opcode_fetch_n,
    output logic translate_n,
    output logic [4:0] mode_out,
    output logic compressed_state_flag,
    output logic [31:0] data_out,
    output logic data_out_en,
    input wire logic [31:0] data_in,
    // Coprocessor handshake
    output logic cop_instr_strobe_n,
    input wire logic cop_absent,
    input wire logic cop_busy
);

    crxs_seq_t s_reg;
    crxs_seq_t s_next;
    crxs_cost_t cost;

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    // Address k instruction lengths ahead of pc; the length follows the state.
    function automatic logic [31:0] pc_plus(input logic [31:0] pc, input logic [1:0] k,
                                            input logic tflag);
        logic [31:0] step;
        step = tflag ? `CRXS_HALF_STEP : `CRXS_WORD_STEP;
        pc_plus = pc + (step * {30'h0, k});
    endfunction : pc_plus

    function automatic logic is_transfer(input crxs_op_t op);
        is_transfer = (op == OP_MRC) || (op == OP_MCR);
    endfunction : is_transfer

    // ------------------------------------------------------------------------
    // Cycle cost calculator
    // ------------------------------------------------------------------------
    crxs_cycle_cost u_cost (
        .clk(clk),
        .rstn(rstn),
        .cls(s_reg.cost_cfg[4:0]),
        .words(s_reg.cost_cfg[15:8]),
        .busy_b(s_reg.cost_cfg[23:16]),
        .multiplier(s_reg.mult),
        .shift_reg(s_reg.cost_cfg[24]),
        .pc_written(s_reg.cost_cfg[25]),
        .cond_fail(s_reg.cost_cfg[26]),
        .cost(cost)
    );

    // ------------------------------------------------------------------------
    // Handshake decode
    // ------------------------------------------------------------------------
    logic cop_ready;
    logic cop_wait;
    logic cop_gone;
    logic wr_fire;
    logic rd_take;

    // Both lines are taken as they stand at the edge that ends the cycle.
    assign cop_ready = !cop_absent && !cop_busy;
    assign cop_wait = !cop_absent && cop_busy;
    assign cop_gone = cop_absent;
    assign wr_fire = avs_write && s_reg.ack;
    assign rd_take = avs_read && !s_reg.ack;

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb begin
        logic do_start;
        logic start_ok;
        s_next = s_reg;
        do_start = wr_fire && (avs_address == `CRXS_REG_CTRL) && avs_writedata[`CRXS_CTRL_START];
        start_ok = 1'b0;

        // One-wait-state slave: the request is answered in its second cycle.
        s_next.ack = (avs_read || avs_write) && !s_reg.ack;
        if (rd_take) begin
            if (avs_address == `CRXS_REG_CTRL) begin
                s_next.rdata = {21'h0, s_reg.trans, s_reg.mode, s_reg.tflag, s_reg.op, 1'b0};
            end else if (avs_address == `CRXS_REG_STATUS) begin
                s_next.rdata = {16'h0, s_reg.busy_cnt, 4'h0, s_reg.refused, s_reg.trap, s_reg.done,
                                s_reg.st != ST_IDLE};
            end else if (avs_address == `CRXS_REG_PC) begin
                s_next.rdata = s_reg.pc;
            end else if (avs_address == `CRXS_REG_SRC) begin
                s_next.rdata = s_reg.src;
            end else if (avs_address == `CRXS_REG_DEST) begin
                s_next.rdata = s_reg.dest;
            end else if (avs_address == `CRXS_REG_VECTOR) begin
                s_next.rdata = s_reg.vector;
            end else if (avs_address == `CRXS_REG_COSTCFG) begin
                s_next.rdata = s_reg.cost_cfg;
            end else if (avs_address == `CRXS_REG_MULT) begin
                s_next.rdata = s_reg.mult;
            end else if (avs_address == `CRXS_REG_COST) begin
                s_next.rdata = cost;
            end else begin
                s_next.rdata = 32'h0000_0000;
            end
        end

        // Configuration writes. Registers that steer a sequence are frozen
        // while it runs so the bus pattern cannot change mid-instruction.
        if (wr_fire) begin
            if (avs_address == `CRXS_REG_STATUS) begin
                s_next.done = s_reg.done & ~avs_writedata[`CRXS_STAT_DONE];
                s_next.trap = s_reg.trap & ~avs_writedata[`CRXS_STAT_TRAP];
                s_next.refused = s_reg.refused & ~avs_writedata[`CRXS_STAT_REFUSED];
            end else if (avs_address == `CRXS_REG_COSTCFG) begin
                s_next.cost_cfg = avs_writedata;
            end else if (avs_address == `CRXS_REG_MULT) begin
                s_next.mult = avs_writedata;
            end else if (s_reg.st == ST_IDLE) begin
                if (avs_address == `CRXS_REG_CTRL) begin
                    s_next.tflag = avs_writedata[`CRXS_CTRL_TFLAG];
                    s_next.mode = avs_writedata[`CRXS_CTRL_MODE_HI:`CRXS_CTRL_MODE_LO];
                    s_next.trans = avs_writedata[`CRXS_CTRL_TRANS];
                end else if (avs_address == `CRXS_REG_PC) begin
                    s_next.pc = avs_writedata;
                end else if (avs_address == `CRXS_REG_SRC) begin
                    s_next.src = avs_writedata;
                end else if (avs_address == `CRXS_REG_VECTOR) begin
                    s_next.vector = avs_writedata;
                end
            end
        end

        // A start takes the state flag written in the same access.
        if (do_start) begin
            if (s_reg.st != ST_IDLE) begin
                s_next.refused = 1'b1;
            end else if (is_transfer(crxs_op_t'(avs_writedata[`CRXS_CTRL_OP_HI:`CRXS_CTRL_OP_LO]))
                         && avs_writedata[`CRXS_CTRL_TFLAG]) begin
                s_next.refused = 1'b1;
            end else if (avs_writedata[`CRXS_CTRL_OP_HI:`CRXS_CTRL_OP_LO] > 3'(OP_CFAIL)) begin
                s_next.refused = 1'b1;
            end else begin
                start_ok = 1'b1;
            end
        end
        if (start_ok) begin
            s_next.op = crxs_op_t'(avs_writedata[`CRXS_CTRL_OP_HI:`CRXS_CTRL_OP_LO]);
            s_next.busy_cnt = 8'h00;
            s_next.st = (s_next.op == OP_CFAIL) ? ST_CFAIL : ST_OFFER;
        end

        s_next.data_oe = 1'b0;
        case (s_reg.st)
            ST_IDLE: begin
            end
            ST_OFFER, ST_WAIT: begin
                if (s_reg.tflag) begin
                    s_next.st = ST_UND_INT;
                end else if (cop_gone) begin
                    s_next.st = ST_UND_INT;
                end else if (cop_wait) begin
                    s_next.st = ST_WAIT;
                    s_next.busy_cnt = s_reg.busy_cnt + 8'h01;
                end else if (s_reg.op == OP_CDP) begin
                    s_next.st = ST_IDLE;
                    s_next.done = 1'b1;
                    s_next.next_addr = pc_plus(s_reg.pc, 2'd3, 1'b0);
                end else begin
                    s_next.st = ST_XFER;
                    if (s_reg.op == OP_MCR) begin
                        s_next.data_out = s_reg.src;
                        s_next.data_oe = 1'b1;
                    end
                end
            end
            ST_XFER: begin
                s_next.next_addr = pc_plus(s_reg.pc, 2'd3, 1'b0);
                if (s_reg.op == OP_MRC) begin
                    s_next.xfer_word = data_in;
                    s_next.st = ST_WBACK;
                end else begin
                    s_next.st = ST_IDLE;
                    s_next.done = 1'b1;
                end
            end
            ST_WBACK: begin
                s_next.dest = s_reg.xfer_word;
                s_next.st = ST_IDLE;
                s_next.done = 1'b1;
            end
            ST_UND_INT: s_next.st = ST_UND_VEC;
            ST_UND_VEC: begin
                s_next.st = ST_UND_VEC4;
                s_next.mode = `CRXS_MODE_UNDEF;
                s_next.tflag = 1'b0;
                s_next.trans = 1'b1;
            end
            ST_UND_VEC4: begin
                s_next.st = ST_IDLE;
                s_next.trap = 1'b1;
                s_next.done = 1'b1;
                s_next.next_addr = s_reg.vector + (`CRXS_WORD_STEP * 32'd2);
            end
            ST_CFAIL: begin
                s_next.st = ST_IDLE;
                s_next.done = 1'b1;
                s_next.next_addr = pc_plus(s_reg.pc, 2'd3, s_reg.tflag);
            end
            default: s_next.st = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_reg <= '0;
            s_reg.st <= ST_IDLE;
            s_reg.op <= OP_MRC;
            s_reg.vector <= `CRXS_VECTOR_RST;
            s_reg.mode <= `CRXS_MODE_RST;
            s_reg.trans <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    // ------------------------------------------------------------------------
    // Bus cycle outputs
    // ------------------------------------------------------------------------
    // Request and sequential look at the coprocessor lines in the same cycle,
    // since they announce what the next cycle will be.
    always_comb begin
        mem_addr = s_reg.next_addr;
        access_size = s_reg.tflag ? `CRXS_SIZE_HALF : `CRXS_SIZE_WORD;
        write_not_read = 1'b0;
        mem_request_n = 1'b1;
        sequential_access = 1'b0;
        opcode_fetch_n = 1'b1;
        cop_instr_strobe_n = 1'b1;
        translate_n = s_reg.trans;
        mode_out = s_reg.mode;
        compressed_state_flag = s_reg.tflag;
        case (s_reg.st)
            ST_IDLE: begin
            end
            ST_OFFER, ST_WAIT: begin
                mem_addr = pc_plus(s_reg.pc, 2'd2, s_reg.tflag);
                opcode_fetch_n = (s_reg.st == ST_WAIT);
                cop_instr_strobe_n = s_reg.tflag;
                if (!s_reg.tflag && cop_ready) begin
                    sequential_access = 1'b1;
                    mem_request_n = (s_reg.op != OP_CDP);
                end
            end
            ST_XFER: begin
                mem_addr = pc_plus(s_reg.pc, 2'd3, 1'b0);
                if (s_reg.op == OP_MCR) begin
                    write_not_read = 1'b1;
                    mem_request_n = 1'b0;
                end
            end
            ST_WBACK: begin
                mem_addr = pc_plus(s_reg.pc, 2'd3, 1'b0);
                mem_request_n = 1'b0;
                sequential_access = 1'b1;
            end
            ST_UND_INT: begin
                mem_addr = pc_plus(s_reg.pc, 2'd2, s_reg.tflag);
                mem_request_n = 1'b0;
                opcode_fetch_n = 1'b0;
            end
            ST_UND_VEC, ST_UND_VEC4: begin
                mem_addr = (s_reg.st == ST_UND_VEC) ? s_reg.vector : s_reg.vector + `CRXS_WORD_STEP;
                access_size = `CRXS_SIZE_WORD;
                mem_request_n = 1'b0;
                sequential_access = 1'b1;
                opcode_fetch_n = 1'b0;
                translate_n = 1'b1;
                mode_out = `CRXS_MODE_UNDEF;
                compressed_state_flag = 1'b0;
            end
            ST_CFAIL: begin
                mem_addr = pc_plus(s_reg.pc, 2'd2, s_reg.tflag);
                mem_request_n = 1'b0;
                sequential_access = 1'b1;
                opcode_fetch_n = 1'b0;
            end
            default: begin
            end
        endcase
    end

    assign data_out = s_reg.data_out;
    assign data_out_en = s_reg.data_oe;
    assign avs_readdata = s_reg.rdata;
    assign avs_waitrequest = (avs_read || avs_write) && !s_reg.ack;

endmodule : crxs_sequencer

// [hw/crxs_defines.svh]
// Constants of the coprocessor register transfer sequencer: register offsets,
// field positions, reset values, access sizes and address steps.
// Assumes inclusion by bare name from the design modules.
`ifndef CRXS_DEFINES_SVH
`define CRXS_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define CRXS_REG_CTRL 8'h00
`define CRXS_REG_STATUS 8'h04
`define CRXS_REG_PC 8'h08
`define CRXS_REG_SRC 8'h0C
`define CRXS_REG_DEST 8'h10
`define CRXS_REG_VECTOR 8'h14
`define CRXS_REG_COSTCFG 8'h18
`define CRXS_REG_MULT 8'h1C
`define CRXS_REG_COST 8'h20

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CRXS_CTRL_START 0
`define CRXS_CTRL_OP_LO 1
`define CRXS_CTRL_OP_HI 3
`define CRXS_CTRL_TFLAG 4
`define CRXS_CTRL_MODE_LO 5
`define CRXS_CTRL_MODE_HI 9
`define CRXS_CTRL_TRANS 10
`define CRXS_STAT_DONE 1
`define CRXS_STAT_TRAP 2
`define CRXS_STAT_REFUSED 3

// ----------------------------------------------------------------------------
// Reset values and fixed codes
// ----------------------------------------------------------------------------
`define CRXS_VECTOR_RST 32'h0000_0004
`define CRXS_MODE_RST 5'h13
`define CRXS_MODE_UNDEF 5'h04
`define CRXS_SIZE_WORD 2'h2
`define CRXS_SIZE_HALF 2'h1
`define CRXS_WORD_STEP 32'h0000_0004
`define CRXS_HALF_STEP 32'h0000_0002

`endif

// [hw/crxs_pkg.sv]
// Types shared by the sequencer and its cycle cost calculator.
// Assumes crxs_defines.svh is on the include path.
package crxs_pkg;

    // ------------------------------------------------------------------------
    // Sequencer states and commands
    // ------------------------------------------------------------------------
    typedef enum logic [3:0] {ST_IDLE, ST_OFFER, ST_WAIT, ST_XFER, ST_WBACK, ST_UND_INT,
        ST_UND_VEC, ST_UND_VEC4, ST_CFAIL} crxs_state_t;

    typedef enum logic [2:0] {OP_MRC, OP_MCR, OP_CDP, OP_UNDEF, OP_CFAIL} crxs_op_t;

    typedef enum logic [4:0] {CLS_DP, CLS_PSR, CLS_LDR, CLS_STR, CLS_LDM, CLS_STM, CLS_SWP,
        CLS_BR, CLS_SWI, CLS_MUL, CLS_MLA, CLS_MULL, CLS_MLAL, CLS_CDP, CLS_LDC, CLS_MCR,
        CLS_MRC} crxs_class_t;

    // ------------------------------------------------------------------------
    // Module state
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] s_cnt;
        logic [7:0] n_cnt;
        logic [7:0] i_cnt;
        logic [7:0] c_cnt;
    } crxs_cost_t;

    typedef struct packed {
        crxs_state_t st;
        crxs_op_t op;
        logic [31:0] pc;
        logic [31:0] src;
        logic [31:0] dest;
        logic [31:0] xfer_word;
        logic [31:0] vector;
        logic [31:0] next_addr;
        logic [4:0] mode;
        logic tflag;
        logic trans;
        logic [7:0] busy_cnt;
        logic done;
        logic trap;
        logic refused;
        logic ack;
        logic [31:0] rdata;
        logic [31:0] data_out;
        logic data_oe;
        logic [31:0] cost_cfg;
        logic [31:0] mult;
    } crxs_seq_t;

endpackage : crxs_pkg

// [hw/crxs_cycle_cost.sv]
// Cycle cost calculator: turns an instruction class and its operands into
// counts of sequential, nonsequential, internal and coprocessor cycles.
// Assumes inputs are static software settings; results lag them by one cycle.
`timescale 1ns/10ps
`include "crxs_defines.svh"

module crxs_cycle_cost
    import crxs_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Instruction description
    input wire logic [4:0] cls,
    input wire logic [7:0] words,
    input wire logic [7:0] busy_b,
    input wire logic [31:0] multiplier,
    input wire logic shift_reg,
    input wire logic pc_written,
    input wire logic cond_fail,
    // Result
    output crxs_cost_t cost
);

    crxs_cost_t cost_reg;
    crxs_cost_t cost_next;

    // Early termination: narrower multipliers stop the array sooner.
    function automatic logic [7:0] mult_m(input logic [31:0] op);
        if ((&op[31:8]) || ~(|op[31:8])) begin
            mult_m = 8'h01;
        end else if ((&op[31:16]) || ~(|op[31:16])) begin
            mult_m = 8'h02;
        end else if ((&op[31:24]) || ~(|op[31:24])) begin
            mult_m = 8'h03;
        end else begin
            mult_m = 8'h04;
        end
    endfunction : mult_m

    always_comb begin
        logic [7:0] m;
        m = mult_m(multiplier);
        cost_next = '0;
        case (crxs_class_t'(cls))
            CLS_DP: begin
                cost_next.s_cnt = 8'h01;
                cost_next.i_cnt = {7'h00, shift_reg};
                if (pc_written) begin
                    cost_next.s_cnt = 8'h02;
                    cost_next.n_cnt = 8'h01;
                end
            end
            CLS_PSR: cost_next.s_cnt = 8'h01;
            CLS_LDR, CLS_LDM: begin
                cost_next.s_cnt = (cls == CLS_LDR) ? 8'h01 : words;
                cost_next.n_cnt = 8'h01;
                cost_next.i_cnt = 8'h01;
                if (pc_written) begin
                    cost_next.s_cnt = cost_next.s_cnt + 8'h01;
                    cost_next.n_cnt = 8'h02;
                end
            end
            CLS_STR: cost_next.n_cnt = 8'h02;
            CLS_STM: begin
                cost_next.s_cnt = words - 8'h01;
                cost_next.n_cnt = 8'h02;
            end
            CLS_SWP: begin
                cost_next.s_cnt = 8'h01;
                cost_next.n_cnt = 8'h02;
                cost_next.i_cnt = 8'h01;
            end
            CLS_BR, CLS_SWI: begin
                cost_next.s_cnt = 8'h02;
                cost_next.n_cnt = 8'h01;
            end
            CLS_MUL, CLS_MLA, CLS_MULL, CLS_MLAL: begin
                cost_next.s_cnt = 8'h01;
                if (cls == CLS_MUL) begin
                    cost_next.i_cnt = m;
                end else if (cls == CLS_MLAL) begin
                    cost_next.i_cnt = m + 8'h02;
                end else begin
                    cost_next.i_cnt = m + 8'h01;
                end
            end
            CLS_CDP: begin
                cost_next.s_cnt = 8'h01;
                cost_next.i_cnt = busy_b;
            end
            CLS_LDC: begin
                cost_next.s_cnt = words - 8'h01;
                cost_next.n_cnt = 8'h02;
                cost_next.i_cnt = busy_b;
            end
            CLS_MCR: begin
                cost_next.n_cnt = 8'h01;
                cost_next.i_cnt = busy_b;
                cost_next.c_cnt = 8'h01;
            end
            CLS_MRC: begin
                cost_next.s_cnt = 8'h01;
                cost_next.i_cnt = busy_b + 8'h01;
                cost_next.c_cnt = 8'h01;
            end
            default: cost_next = '0;
        endcase
        if (cond_fail) begin
            cost_next = '0;
            cost_next.s_cnt = 8'h01;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cost_reg <= '0;
        end else begin
            cost_reg <= cost_next;
        end
    end

    assign cost = cost_reg;

endmodule : crxs_cycle_cost

// [dv/crxs_seq_properties.sv]
// Checker on the sequencer strobes and handshake.
// Assumes a bind onto crxs_sequencer.
`timescale 1ns/10ps
module crxs_chk (
    // Watched ports
    input wire logic clk, rstn, avs_read, avs_write, avs_waitrequest, write_not_read,
    input wire logic mem_request_n, sequential_access, opcode_fetch_n, compressed_state_flag,
    input wire logic data_out_en, cop_instr_strobe_n, cop_absent, cop_busy,
    input wire logic [31:0] mem_addr,
    input wire logic [4:0] mode_out
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    wire logic cpi = !cop_instr_strobe_n;
    wire logic go = cpi && !cop_absent && !cop_busy;
    property p_bus; $rose(avs_read | avs_write) |-> avs_waitrequest ##1 !avs_waitrequest; endproperty
    a_bus: assert property (p_bus) else $error("bad wait state");
    property p_seq; cpi && !cop_absent |-> mem_request_n && sequential_access == !cop_busy; endproperty
    a_seq: assert property (p_seq) else $error("bad wait strobes");
    property p_hold; cpi && !cop_absent && cop_busy |=> cpi && opcode_fetch_n && $stable(mem_addr); endproperty
    a_hold: assert property (p_hold) else $error("wait not held");
    property p_go; go |=> !cpi; endproperty
    a_go: assert property (p_go) else $error("offer repeated");
    property p_load; go ##1 mem_request_n |-> !sequential_access ##1 !mem_request_n && sequential_access; endproperty
    a_load: assert property (p_load) else $error("bad load cycles");
    property p_store; write_not_read |-> data_out_en && !mem_request_n && !sequential_access; endproperty
    a_store: assert property (p_store) else $error("bad store cycle");
    property p_tflag; compressed_state_flag |-> !cpi; endproperty
    a_tflag: assert property (p_tflag) else $error("strobe in compressed state");
    property p_trap; cpi && cop_absent |=> !mem_request_n && !sequential_access ##1 mode_out == 5'h04; endproperty
    a_trap: assert property (p_trap) else $error("bad trap cycles");
endmodule : crxs_chk
bind crxs_sequencer crxs_chk i_crxs_chk (.*);

// [dv/crxs_cop_model.sv]
// Coprocessor model: accepts after n_wait busy cycles or refuses.
// Assumes the bench sets its controls between transfers.
`timescale 1ns/10ps
module crxs_cop_model (
    // Clock, reset and bench controls
    input wire logic clk, rstn, refuse,
    input wire logic [7:0] n_wait,
    input wire logic [31:0] word,
    // Core side
    input wire logic cop_instr_strobe_n,
    output logic cop_absent, cop_busy,
    output logic [31:0] data_in
);
    logic [7:0] cnt_reg;
    logic give_reg;
    assign cop_absent = cop_instr_strobe_n | refuse;
    assign cop_busy = cop_absent | (cnt_reg < n_wait);
    // Outside its transfer cycle the bus shows the inverse word, so a stale sample cannot match.
    assign data_in = give_reg ? word : ~word;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_reg <= 8'h00;
            give_reg <= 1'b0;
        end else begin
            cnt_reg <= cop_instr_strobe_n ? 8'h00 : cnt_reg + 8'h01;
            give_reg <= !cop_absent && !cop_busy;
        end
    end
endmodule : crxs_cop_model

// [dv/tb_top.sv]
// Bench for the sequencer: bus tasks and one task per scenario.
// Assumes the coprocessor model and the bound checker.
`timescale 1ns/10ps
module tb_top;
    logic clk = 1'b0, rstn = 1'b0, avs_read = 1'b0, avs_write = 1'b0, refuse = 1'b0;
    logic [7:0] avs_address = '0, n_wait = '0;
    logic [31:0] avs_writedata = '0, word = '0, avs_readdata, mem_addr, data_out, data_in, st_d, st_a;
    logic [4:0] mode_out;
    logic [1:0] access_size;
    logic avs_waitrequest, write_not_read, mem_request_n, sequential_access, opcode_fetch_n, translate_n;
    logic compressed_state_flag, data_out_en, cop_instr_strobe_n, cop_absent, cop_busy;
    int n_fail = 0, total_checks = 0;
    always #25 clk = ~clk;
    crxs_sequencer i_crxs_sequencer (.*);
    crxs_cop_model i_crxs_cop_model (.*);
    always @(posedge clk) if (data_out_en === 1'b1) {st_d, st_a} <= {data_out, mem_addr};
    task automatic chk(input logic [47:0] g, e);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value at %0t: %h, expected %h", $time, g, e);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        {avs_address, avs_writedata, avs_write, avs_read} <= {a, d, w, !w};
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        {avs_write, avs_read} <= 2'b00;
    endtask : bus
    task automatic run(input logic [2:0] op, input logic f, output logic [31:0] s);
        logic [31:0] q;
        bus(1'b1, 8'h00, 32'h0000_0661 | {f, op, 1'b0}, q);
        repeat (40) if (s[1] !== 1'b1) bus(1'b0, 8'h04, '0, s);
        chk(s[1], 1'b1);
        bus(1'b1, 8'h04, 32'h0000_000E, q);
    endtask : run
    task automatic t_load(input logic [7:0] w);
        logic [31:0] s, q;
        {refuse, n_wait, word} <= {1'b0, w, 32'hA5C3_0F00 ^ w};
        run(3'd0, 1'b0, s);
        bus(1'b0, 8'h10, '0, q);
        chk({s[15:8], q}, {w, 32'hA5C3_0F00 ^ w});
    endtask : t_load
    task automatic t_store;
        logic [31:0] q;
        bus(1'b1, 8'h0C, 32'h1234_5678, q);
        run(3'd1, 1'b0, q);
        chk({st_d, st_a[7:0]}, {32'h1234_5678, 8'h0C});
    endtask : t_store
    task automatic t_trap(input logic [2:0] op, input logic f);
        logic [31:0] s;
        refuse <= 1'b1;
        run(op, f, s);
        chk({s[2], mode_out, mem_addr, translate_n, access_size},
            {1'b1, 5'h04, 32'h0000_000C, 1'b1, 2'h2});
    endtask : t_trap
    task automatic t_cfail;
        logic [31:0] s;
        run(3'd4, 1'b0, s);
        chk(mem_addr, 32'h0000_020C);
    endtask : t_cfail
    task automatic t_cost(input logic [31:0] c, m, e);
        logic [31:0] q;
        bus(1'b1, 8'h1C, m, q);
        bus(1'b1, 8'h18, c, q);
        bus(1'b0, 8'h20, '0, q);
        chk(q, e);
    endtask : t_cost
    task automatic end_sim;
        $display("checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_sim
    initial begin
        logic [31:0] q;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        bus(1'b1, 8'h08, 32'h0000_0200, q);
        t_load(8'h03);
        t_store;
        t_trap(3'd0, 1'b0);
        t_trap(3'd3, 1'b1);
        t_cfail;
        t_cost(32'h0000_0305, '0, 32'h0202_0000);
        t_cost(32'h0000_000A, 32'h0012_3456, 32'h0100_0400);
        t_cost(32'h0002_0010, '0, 32'h0100_0301);
        t_cost(32'h0300_0000, '0, 32'h0201_0100);
        t_cost(32'h0000_0007, '0, 32'h0201_0000);
        t_cost(32'h0400_0009, '0, 32'h0100_0000);
        end_sim;
    end
    initial begin
        #2_000_000;
        n_fail++;
        end_sim;
    end
endmodule : tb_top
